//--- ext_bus_pkg.sv
// Purpose: shared constants for the external memory bus pin logic
// Assumes: clock runs at 250 MHz, one machine cycle is a fixed count of clocks
// Notes:   phase windows are counted from phase 0 of each machine cycle
package ext_bus_pkg;

    // machine cycle framing
    localparam int unsigned PHASES_PER_CYCLE = 12;
    localparam logic [3:0]  PHASE_LAST       = 4'hB;
    localparam logic [3:0]  PHASE_HALF       = 4'h6;

    // address latch strobe windows, one per half cycle
    localparam logic [3:0]  ALE_A_START      = 4'h0;
    localparam logic [3:0]  ALE_A_END        = 4'h1;
    localparam logic [3:0]  ALE_B_START      = 4'h6;
    localparam logic [3:0]  ALE_B_END        = 4'h7;

    // program-fetch strobe windows
    localparam logic [3:0]  FETCH_A_START    = 4'h2;
    localparam logic [3:0]  FETCH_A_END      = 4'h4;
    localparam logic [3:0]  FETCH_B_START    = 4'h8;
    localparam logic [3:0]  FETCH_B_END      = 4'hA;

    // external data strobe window, inside the second half
    localparam logic [3:0]  DATA_STB_START   = 4'h7;
    localparam logic [3:0]  DATA_STB_END     = 4'hA;

    // control port strobe bit positions
    localparam int unsigned WRITE_STROBE_BIT = 6;
    localparam int unsigned READ_STROBE_BIT  = 7;

    // reset pin timing in machine cycles
    localparam int unsigned RESET_HOLD_CYCLES = 2;
    localparam int unsigned HOST_ENTRY_CYCLES = 20;

    localparam logic [7:0]  PORT_IDLE        = 8'hFF;
    localparam logic [15:0] ADDR_ZERO        = 16'h0000;

endpackage

//--- reset_link_if.sv
// Purpose: carries machine cycle timing and reset state between bus and reset logic
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/10ps
interface reset_link_if;
    logic cycle_tick;
    logic fetch_pin_level;
    logic device_reset;
    logic host_mode;

    modport bus_side (
        output cycle_tick,
        output fetch_pin_level,
        input  device_reset,
        input  host_mode
    );
    modport reset_side (
        input  cycle_tick,
        input  fetch_pin_level,
        output device_reset,
        output host_mode
    );
endinterface

//--- reset_entry.sv
// Purpose: reset pin qualification and external host mode entry
// Assumes: reset pin and fetch strobe pin are synchronous to clock
// Notes:   counts whole machine cycles while the reset pin stays high
`timescale 1ns/10ps
module reset_entry
    import ext_bus_pkg::*;
#(
    parameter int unsigned COUNT_WIDTH = 5
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         sys_rst,
    // device reset pin
    input  wire logic         reset_pin,
    // link to bus logic
    reset_link_if.reset_side  link
);

    if ((2 ** COUNT_WIDTH) <= HOST_ENTRY_CYCLES + 1) begin : g_width_check
        $error("reset_entry: COUNT_WIDTH too small");
    end

    localparam logic [COUNT_WIDTH-1:0] HOLD_COUNT  = COUNT_WIDTH'(RESET_HOLD_CYCLES);
    localparam logic [COUNT_WIDTH-1:0] ENTRY_COUNT = COUNT_WIDTH'(HOST_ENTRY_CYCLES);

    typedef struct packed {
        logic [COUNT_WIDTH-1:0] held;
        logic                   fetch_prev;
        logic                   device_reset;
        logic                   host_mode;
    } entry_state_t;

    entry_state_t state;
    entry_state_t next_state;

    always_comb begin
        next_state            = state;
        next_state.fetch_prev = link.fetch_pin_level;
        if (!reset_pin) begin
            next_state.held         = '0;
            next_state.device_reset = 1'b0;
        end else begin
            if (link.cycle_tick && state.held <= ENTRY_COUNT)
                next_state.held = state.held + COUNT_WIDTH'(1);
            if (state.held >= HOLD_COUNT)
                next_state.device_reset = 1'b1;
            if (state.held == HOLD_COUNT)
                next_state.host_mode = 1'b0;
            // falling edge on the strobe pin after a long enough reset
            if (state.held > ENTRY_COUNT && state.fetch_prev && !link.fetch_pin_level)
                next_state.host_mode = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= '{held: '0, fetch_prev: 1'b1, device_reset: 1'b1, host_mode: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign link.device_reset = state.device_reset;
    assign link.host_mode    = state.host_mode;

endmodule // reset_entry

//--- ext_bus_pins.sv
// Purpose: external memory bus pin sequencing for fetch and data accesses
// Assumes: core inputs synchronous to clock; low byte bus handled elsewhere
// Notes:   fixed twelve-clock machine cycle
`timescale 1ns/10ps
module ext_bus_pins
    import ext_bus_pkg::*;
#(
    parameter int unsigned RESET_COUNT_WIDTH = 5
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // device pins: reset and execution select
    input  wire logic        reset_pin,
    input  wire logic        external_exec,
    // program fetch strobe pin
    output logic             program_fetch_strobe_n_out,
    output logic             program_fetch_strobe_n_oe_n,
    input  wire logic        program_fetch_strobe_n_in,
    // address latch strobe and low address byte
    output logic             address_latch_strobe,
    output logic [7:0]       low_address,
    // high-address port pins
    output logic [7:0]       high_address_port_out,
    output logic [7:0]       high_address_port_oe_n,
    output logic [7:0]       high_address_port_pull,
    input  wire logic [7:0]  high_address_port_in,
    // control port pins
    output logic [7:0]       control_port_out,
    output logic [7:0]       control_port_oe_n,
    output logic [7:0]       control_port_pull,
    input  wire logic [7:0]  control_port_in,
    // port output latches from the core
    input  wire logic [7:0]  high_port_latch,
    input  wire logic [7:0]  control_port_latch,
    // core fetch address
    input  wire logic [15:0] fetch_address,
    // core data access request
    input  wire logic        data_valid,
    output logic             data_ready,
    input  wire logic        data_write,
    input  wire logic        data_wide,
    input  wire logic [15:0] data_address,
    output logic             data_done,
    // status
    output logic             device_reset,
    output logic             host_mode,
    output logic [7:0]       host_high_address,
    output logic [7:0]       host_control
);

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        if (PHASES_PER_CYCLE != 32'(PHASE_LAST) + 1)
            $error("ext_bus_pins: phase framing inconsistent");
    end

    typedef struct packed {
        logic [3:0]  phase;
        logic        pending;
        logic        data_cycle;
        logic        access_write;
        logic        access_wide;
        logic [15:0] access_addr;
        logic        done;
        logic        ale;
        logic [7:0]  low_addr;
        logic        fetch_out;
        logic        fetch_oe_n;
        logic [7:0]  hi_out;
        logic [7:0]  hi_oe_n;
        logic [7:0]  hi_pull;
        logic [7:0]  ctl_out;
        logic [7:0]  ctl_oe_n;
        logic [7:0]  ctl_pull;
        logic [7:0]  host_hi;
        logic [7:0]  host_ctl;
    } bus_state_t;

    bus_state_t state;
    bus_state_t next_state;

    reset_link_if link ();

    reset_entry #(
        .COUNT_WIDTH (RESET_COUNT_WIDTH)
    ) u_reset_entry (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .reset_pin (reset_pin),
        .link      (link.reset_side)
    );

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic in_window(input logic [3:0] ph, input logic [3:0] lo,
                                       input logic [3:0] hi);
        in_window = (ph >= lo) && (ph <= hi);
    endfunction

    // returns {out, oe_n, pull}; forced bits drive strongly, latch ones only pull
    function automatic logic [23:0] port_pins(input logic [7:0] latch,
                                              input logic [7:0] force_mask,
                                              input logic [7:0] force_val);
        logic [7:0] out_v;
        logic [7:0] oe_v;
        logic [7:0] pull_v;
        out_v  = (force_mask & force_val);
        oe_v   = ~(force_mask | ~latch);
        pull_v = ~force_mask & latch;
        port_pins = {out_v, oe_v, pull_v};
    endfunction

    logic        first_half;
    logic        active;
    logic        strobe_win;
    logic        use_data_addr;
    logic [7:0]  hi_force;
    logic [7:0]  hi_value;
    logic [7:0]  ctl_force;
    logic [7:0]  ctl_value;

    always_comb begin
        next_state      = state;
        first_half      = (state.phase < PHASE_HALF);
        active          = !link.device_reset && !link.host_mode;
        strobe_win      = state.data_cycle && in_window(state.phase, DATA_STB_START,
                                                         DATA_STB_END);
        use_data_addr   = state.data_cycle && !first_half;
        hi_force        = 8'h00;
        hi_value        = 8'h00;
        ctl_force       = 8'h00;
        ctl_value       = PORT_IDLE;

        next_state.phase = (state.phase == PHASE_LAST) ? 4'h0 : state.phase + 4'h1;
        next_state.done  = 1'b0;

        // data request handshake
        if (data_valid && !state.pending) begin
            next_state.pending      = 1'b1;
            next_state.access_write = data_write;
            next_state.access_wide  = data_wide;
            next_state.access_addr  = data_address;
        end
        if (state.phase == PHASE_LAST) begin
            next_state.data_cycle = state.pending && !state.data_cycle && active;
            if (state.data_cycle) begin
                next_state.pending = 1'b0;
                next_state.done    = 1'b1;
            end
        end
        if (!active) begin
            next_state.data_cycle = 1'b0;
        end

        // upper address byte; wide data address held for the whole second half, narrow leaves the port to its latch
        if (active) begin
            if (use_data_addr && state.access_wide) begin
                hi_force = PORT_IDLE;
                hi_value = state.access_addr[15:8];
            end else if (use_data_addr) begin
                hi_force = 8'h00;
            end else if (external_exec) begin
                hi_force = PORT_IDLE;
                hi_value = fetch_address[15:8];
            end
            if (strobe_win) begin
                ctl_force[WRITE_STROBE_BIT] = state.access_write;
                ctl_value[WRITE_STROBE_BIT] = 1'b0;
                ctl_force[READ_STROBE_BIT]  = !state.access_write;
                ctl_value[READ_STROBE_BIT]  = 1'b0;
            end
        end

        {next_state.hi_out, next_state.hi_oe_n, next_state.hi_pull} =
            port_pins(high_port_latch, hi_force, hi_value);
        {next_state.ctl_out, next_state.ctl_oe_n, next_state.ctl_pull} =
            port_pins(control_port_latch, ctl_force, ctl_value);

        // address latch strobe on each half, carrying the address of that half
        // a pulse only starts at its window start, so leaving reset never cuts one short
        next_state.ale = (in_window(state.phase, ALE_A_START, ALE_A_END)
                          || in_window(state.phase, ALE_B_START, ALE_B_END))
                         && (state.ale || (active && (state.phase == ALE_A_START
                                                      || state.phase == ALE_B_START)));
        if (!active) begin
            next_state.low_addr = 8'h00;
        end else if (use_data_addr) begin
            next_state.low_addr = state.access_addr[7:0];
        end else begin
            next_state.low_addr = fetch_address[7:0];
        end

        // fetch strobe: high when internal, two pulses when external, only the first in a data cycle
        next_state.fetch_oe_n = link.host_mode;
        next_state.fetch_out  = 1'b1;
        if (active && external_exec) begin
            if (in_window(state.phase, FETCH_A_START, FETCH_A_END))
                next_state.fetch_out = 1'b0;
            if (in_window(state.phase, FETCH_B_START, FETCH_B_END) && !state.data_cycle)
                next_state.fetch_out = 1'b0;
        end

        // host programming: release both ports and take their levels in
        if (link.host_mode) begin
            next_state.hi_oe_n  = PORT_IDLE;
            next_state.ctl_oe_n = PORT_IDLE;
            next_state.hi_pull  = PORT_IDLE;
            next_state.ctl_pull = PORT_IDLE;
            next_state.host_hi  = high_address_port_in;
            next_state.host_ctl = control_port_in;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= '{phase: 4'h0, pending: 1'b0, data_cycle: 1'b0, access_write: 1'b0,
                       access_wide: 1'b0, access_addr: ADDR_ZERO, done: 1'b0, ale: 1'b0,
                       low_addr: 8'h00, fetch_out: 1'b1, fetch_oe_n: 1'b0,
                       hi_out: 8'h00, hi_oe_n: PORT_IDLE, hi_pull: PORT_IDLE,
                       ctl_out: 8'h00, ctl_oe_n: PORT_IDLE, ctl_pull: PORT_IDLE,
                       host_hi: 8'h00, host_ctl: 8'h00};
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign link.cycle_tick      = (state.phase == PHASE_LAST);
    assign link.fetch_pin_level = program_fetch_strobe_n_in;

    assign program_fetch_strobe_n_out  = state.fetch_out;
    assign program_fetch_strobe_n_oe_n = state.fetch_oe_n;
    assign address_latch_strobe        = state.ale;
    assign low_address                 = state.low_addr;
    assign high_address_port_out       = state.hi_out;
    assign high_address_port_oe_n      = state.hi_oe_n;
    assign high_address_port_pull      = state.hi_pull;
    assign control_port_out            = state.ctl_out;
    assign control_port_oe_n           = state.ctl_oe_n;
    assign control_port_pull           = state.ctl_pull;
    // one request held at a time; the next waits for the done pulse
    assign data_ready                  = !state.pending;
    assign data_done                   = state.done;
    assign device_reset                = link.device_reset;
    assign host_mode                   = link.host_mode;
    assign host_high_address           = state.host_hi;
    assign host_control                = state.host_ctl;

endmodule // ext_bus_pins

//--- ext_bus_pins_monitor.sv
// Purpose: pin protocol checker for the external bus block
// Assumes: sees top ports only, one clock domain
// Notes:   pin outputs lag the machine cycle phase by one clock
`timescale 1ns/10ps
module ext_bus_pins_monitor
    import ext_bus_pkg::*;
#(
    parameter int unsigned RESET_COUNT_WIDTH = 5
) (
    // clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // pins
    input wire logic       reset_pin,
    input wire logic       external_exec,
    input wire logic       program_fetch_strobe_n_out,
    input wire logic       program_fetch_strobe_n_oe_n,
    input wire logic       program_fetch_strobe_n_in,
    input wire logic       address_latch_strobe,
    input wire logic [7:0] high_address_port_out,
    input wire logic [7:0] high_address_port_oe_n,
    input wire logic [7:0] control_port_out,
    input wire logic [7:0] control_port_oe_n,
    // status
    input wire logic       data_done,
    input wire logic       device_reset,
    input wire logic       host_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // a qualified reset needs 13+ clocks, so short spans guarded by run stay clean
    wire run    = !reset_pin && !device_reset && !host_mode;
    wire wr_low = !control_port_out[WRITE_STROBE_BIT] && !control_port_oe_n[WRITE_STROBE_BIT];
    wire rd_low = !control_port_out[READ_STROBE_BIT] && !control_port_oe_n[READ_STROBE_BIT];
    ////////////////////////////////////////////////////////////////////////////////
    property p_internal_idle;
        !external_exec && $past(!external_exec) && !host_mode |-> program_fetch_strobe_n_out;
    endproperty
    a_internal_idle: assert property (p_internal_idle)
        else $error("fetch strobe active in internal run");
    property p_fetch_width;
        $fell(program_fetch_strobe_n_out) && run |=>
            !program_fetch_strobe_n_out [*2] ##1 program_fetch_strobe_n_out;
    endproperty
    a_fetch_width: assert property (p_fetch_width)
        else $error("fetch pulse width wrong");
    property p_fetch_gap;
        $rose(program_fetch_strobe_n_out) && external_exec && run |->
            ##[3:9] ($fell(program_fetch_strobe_n_out) || !external_exec);
    endproperty
    a_fetch_gap: assert property (p_fetch_gap)
        else $error("fetch pulse missing");
    property p_done_omit;
        data_done |-> $past(program_fetch_strobe_n_out, 2);
    endproperty
    a_done_omit: assert property (p_done_omit)
        else $error("second fetch pulse not omitted");
    property p_write_len;
        $rose(wr_low) && run |=> wr_low [*3] ##1 !wr_low && !rd_low;
    endproperty
    a_write_len: assert property (p_write_len)
        else $error("write strobe length wrong");
    property p_read_len;
        $rose(rd_low) && run |=> rd_low [*3] ##1 !rd_low && !wr_low;
    endproperty
    a_read_len: assert property (p_read_len)
        else $error("read strobe length wrong");
    property p_hi_stable;
        (wr_low || rd_low) && $past(wr_low || rd_low) |->
            $stable(high_address_port_out) && $stable(high_address_port_oe_n);
    endproperty
    a_hi_stable: assert property (p_hi_stable)
        else $error("high address moved under strobe");
    property p_ale;
        $rose(address_latch_strobe) && run |=> address_latch_strobe ##1 !address_latch_strobe;
    endproperty
    a_ale: assert property (p_ale)
        else $error("latch strobe width wrong");
    property p_reset_clear;
        $fell(reset_pin) |-> ##[1:2] !device_reset;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("device reset stuck");
    property p_host_entry;
        $rose(host_mode) |-> !$past(program_fetch_strobe_n_in) && $past(reset_pin, 240);
    endproperty
    a_host_entry: assert property (p_host_entry)
        else $error("host mode entered without cause");
    property p_host_release;
        host_mode && $past(host_mode) |->
            high_address_port_oe_n == PORT_IDLE && program_fetch_strobe_n_oe_n;
    endproperty
    a_host_release: assert property (p_host_release)
        else $error("pins driven in host mode");
endmodule // ext_bus_pins_monitor

bind ext_bus_pins ext_bus_pins_monitor #(.RESET_COUNT_WIDTH(RESET_COUNT_WIDTH)) mon (
    .clock, .sys_rst, .reset_pin, .external_exec, .program_fetch_strobe_n_out,
    .program_fetch_strobe_n_oe_n, .program_fetch_strobe_n_in, .address_latch_strobe,
    .high_address_port_out, .high_address_port_oe_n, .control_port_out, .control_port_oe_n,
    .data_done, .device_reset, .host_mode);

//--- ext_mem_model.sv
// Purpose: outside world at the pins: port and fetch pin levels and host programmer
// Assumes: levels resolved combinationally
// Notes:   released pins without pull show the inverse of the last value
`timescale 1ns/10ps
module ext_mem_model (
    // device pins
    input wire logic       program_fetch_strobe_n_out,
    input wire logic       program_fetch_strobe_n_oe_n,
    input wire logic [7:0] high_address_port_out,
    input wire logic [7:0] high_address_port_oe_n,
    input wire logic [7:0] high_address_port_pull,
    input wire logic [7:0] control_port_out,
    input wire logic [7:0] control_port_oe_n,
    input wire logic [7:0] control_port_pull,
    output logic           program_fetch_strobe_n_in,
    output logic [7:0]     high_address_port_in,
    output logic [7:0]     control_port_in,
    // programmer controls
    input wire logic       force_fetch_low,
    input wire logic       prog_en,
    input wire logic [7:0] prog_high,
    input wire logic [7:0] prog_ctl
);
    // an outside driver beats the weak pull but never a strong drive
    function automatic logic [7:0] lvl(input logic [7:0] o, oe_n, pull, drv, input logic en);
        for (int i = 0; i < 8; i++)
            lvl[i] = !oe_n[i] ? o[i] : en ? drv[i] : pull[i] ? 1'b1 : !o[i];
    endfunction
    assign high_address_port_in = lvl(high_address_port_out, high_address_port_oe_n,
                                      high_address_port_pull, prog_high, prog_en);
    assign control_port_in = lvl(control_port_out, control_port_oe_n,
                                 control_port_pull, prog_ctl, prog_en);
    // forced low overrides the device driver, as a strong programmer would
    assign program_fetch_strobe_n_in = force_fetch_low ? 1'b0 :
        (!program_fetch_strobe_n_oe_n ? program_fetch_strobe_n_out
                                      : !program_fetch_strobe_n_out);
endmodule // ext_mem_model

//--- testbench.sv
// Purpose: self-checking bench for the external bus pin block
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   expectations follow the phase layout of the package
`timescale 1ns/10ps
module testbench;
    logic        clock, sys_rst, reset_pin, external_exec, data_valid, data_write, data_wide;
    logic        program_fetch_strobe_n_out, program_fetch_strobe_n_oe_n;
    logic        program_fetch_strobe_n_in, address_latch_strobe, data_ready, data_done;
    logic        device_reset, host_mode, force_fetch_low, prog_en;
    logic [7:0]  low_address, high_address_port_out, high_address_port_oe_n;
    logic [7:0]  high_address_port_pull, high_address_port_in, control_port_out;
    logic [7:0]  control_port_oe_n, control_port_pull, control_port_in, high_port_latch;
    logic [7:0]  control_port_latch, host_high_address, host_control, prog_high, prog_ctl;
    logic [15:0] fetch_address, data_address;
    int          miscompares = 0;
    int          n_tests = 0;
    ////////////////////////////////////////////////////////////////////////////////
    ext_bus_pins #(.RESET_COUNT_WIDTH(5)) dut (.clock, .sys_rst, .reset_pin, .external_exec,
        .program_fetch_strobe_n_out, .program_fetch_strobe_n_oe_n, .program_fetch_strobe_n_in,
        .address_latch_strobe, .low_address, .high_address_port_out, .high_address_port_oe_n,
        .high_address_port_pull, .high_address_port_in, .control_port_out, .control_port_oe_n,
        .control_port_pull, .control_port_in, .high_port_latch, .control_port_latch,
        .fetch_address, .data_valid, .data_ready, .data_write, .data_wide, .data_address,
        .data_done, .device_reset, .host_mode, .host_high_address, .host_control);
    ext_mem_model mem (.program_fetch_strobe_n_out, .program_fetch_strobe_n_oe_n,
        .high_address_port_out, .high_address_port_oe_n, .high_address_port_pull,
        .control_port_out, .control_port_oe_n, .control_port_pull, .program_fetch_strobe_n_in,
        .high_address_port_in, .control_port_in, .force_fetch_low, .prog_en, .prog_high,
        .prog_ctl);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // change execution source at a clock where the latch strobe is high, never mid fetch pulse
    task automatic set_exec(input logic e);
        repeat (12) if (address_latch_strobe !== 1'b1) step();
        external_exec = e;
    endtask
    task automatic t_fetch(input logic e);
        int lo = 0;
        int al = 0;
        set_exec(e);
        fetch_address = 16'hA55A;
        step(12);
        repeat (24) begin
            lo += (program_fetch_strobe_n_out === 1'b0);
            al += (address_latch_strobe === 1'b1);
            step();
        end
        check(lo, e ? 16'h000C : 16'h0000);
        check(al, 16'h0008);
        check(low_address, 16'h005A);
        if (e) check({high_address_port_oe_n, high_address_port_out}, 16'h00A5);
    endtask
    task automatic t_latch();
        high_port_latch = 8'h5A;
        control_port_latch = 8'hC3;
        prog_en = 1'b1;
        prog_high = 8'h0F;
        step(3);
        check({high_address_port_oe_n, high_address_port_pull}, 16'h5A5A);
        check({high_address_port_out & 8'hA5, high_address_port_in}, 16'h000A);
        check({control_port_oe_n, control_port_pull}, 16'hC3C3);
        {high_port_latch, control_port_latch, prog_en} = 17'h1FFFE;
        step(3);
    endtask
    task automatic t_data(input logic wr, input logic wide, input logic [15:0] addr);
        logic [11:0] hist = 12'hFFF;
        int sw = 0;
        int sr = 0;
        int bad = 0;
        {data_valid, data_write, data_wide, data_address} = {1'b1, wr, wide, addr};
        step();
        data_valid = 1'b0;
        repeat (40) if (data_done !== 1'b1) begin
            hist = {hist[10:0], program_fetch_strobe_n_out};
            sw += (control_port_out[6] === 1'b0 && control_port_oe_n[6] === 1'b0);
            sr += (control_port_out[7] === 1'b0 && control_port_oe_n[7] === 1'b0);
            if (control_port_oe_n[6] === 1'b0 || control_port_oe_n[7] === 1'b0)
                bad += (low_address !== addr[7:0]) +
                       (wide ? (high_address_port_out !== addr[15:8] ||
                                high_address_port_oe_n !== 8'h00)
                             : (high_address_port_oe_n !== 8'hFF));
            step();
        end
        check({data_done, data_ready}, 16'h0003);
        check(12 - $countones(hist), 16'h0003);
        check({sw[7:0], sr[7:0]}, wr ? 16'h0400 : 16'h0004);
        check(bad, 16'h0000);
        step(2);
    endtask
    task automatic t_reset_pin();
        int hits = 0;
        set_exec(1'b0);
        reset_pin = 1'b1;
        repeat (6) begin
            step();
            hits += (device_reset === 1'b1);
        end
        reset_pin = 1'b0;
        step(2);
        check(hits, 16'h0000);
        reset_pin = 1'b1;
        step(36);
        check(device_reset, 1'b1);
        reset_pin = 1'b0;
        step(2);
        check(device_reset, 1'b0);
    endtask
    task automatic t_host();
        reset_pin = 1'b1;
        step(120);
        force_fetch_low = 1'b1;
        step(2);
        check(host_mode, 1'b0);
        force_fetch_low = 1'b0;
        step(146);
        force_fetch_low = 1'b1;
        step(2);
        check(host_mode, 1'b1);
        {prog_en, prog_high, prog_ctl} = 17'h15A3C;
        step(3);
        check({host_high_address, host_control}, 16'h5A3C);
        check({high_address_port_oe_n, control_port_oe_n}, 16'hFFFF);
        {reset_pin, force_fetch_low} = 2'h0;
        step(3);
        reset_pin = 1'b1;
        step(36);
        {reset_pin, prog_en} = 2'h0;
        step(3);
        check(host_mode, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        step(20000);
        miscompares++;
        give_verdict();
    end
    initial begin
        {sys_rst, reset_pin, external_exec, data_valid, data_write, data_wide} = 6'h20;
        {high_port_latch, control_port_latch, fetch_address, data_address} = 48'hFFFF00000000;
        {force_fetch_low, prog_en, prog_high, prog_ctl} = 18'h00000;
        step(6);
        sys_rst = 1'b0;
        step(2);
        t_fetch(1'b0);
        t_latch();
        t_fetch(1'b1);
        for (int i = 0; i < 4; i++)
            t_data(i[1], i[0], 16'h3C00 + 16'(i * 16'h4101));
        t_reset_pin();
        t_host();
        give_verdict();
    end
endmodule // testbench
